/* hdl/sqa_pkg.sv */
// Shared constants for the squib arming serial link and its two ends.
package sqa_pkg;
  // Number of deployment channels.
  localparam int NCH = 4;
  // Frame lengths in bits for the deploy, sensor and arming ports.
  localparam int DEP_BITS = 16;
  localparam int SENS_BITS = 64;
  localparam int ARM_BITS = 8;
  // Width of the free-running edge counters on each link clock.
  localparam int CNT_W = 8;
  // System clock period in picoseconds (200 MHz).
  localparam int CLK_PS = 5000;
  // Select pulses this short or shorter are spurious.
  localparam int SPUR_NS = 50;
  localparam int SPUR_CYC = (SPUR_NS * 1000) / CLK_PS;
  // Default fire duration and pulse stretch duration, in microseconds.
  localparam int FIRE_US = 2000;
  localparam int STRETCH_US = 10000;
  // Divide first so the product stays inside a 32-bit integer.
  localparam int FIRE_CYC_DEF = FIRE_US * (1000000 / CLK_PS);
  localparam int STRETCH_CYC_DEF = STRETCH_US * (1000000 / CLK_PS);
  // Width of the stretch and fire down-counters.
  localparam int TMR_W = 24;
  // Command field positions: enable bits above, disable bits below.
  localparam int EN_LSB = 4;
  localparam int DIS_LSB = 0;
  // Answer after a deploy frame with a bad clock count.
  localparam logic [15:0] DEP_FAULT_RSP = 16'hFF00;
  // Code pushed to the sensor queue after a bad sensor clock count.
  localparam logic [63:0] SENS_BITCNT_FAULT = 64'hFFFF_0000_0000_0001;
  // Master timing: half clock period, lead, lag and select off time in cycles.
  localparam int HALF_NS = 95;
  localparam int LEAD_NS = 65;
  localparam int LAG_NS = 50;
  localparam int SEL_OFF_NS = 500;
  localparam int HALF_CYC = (HALF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int LEAD_CYC = (LEAD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int LAG_CYC = (LAG_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SEL_OFF_CYC = (SEL_OFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Port codes for a master request.
  localparam logic [1:0] PORT_DEP = 2'h0;
  localparam logic [1:0] PORT_SENS = 2'h1;
  localparam logic [1:0] PORT_ARM = 2'h2;
endpackage : sqa_pkg

/* hdl/sqa_link_if.sv */
// Serial link pins between the master and the squib arming device.
`timescale 1ns/1ps
interface sqa_link_if;
  // Shared clock, data and selects of the deploy and sensor ports.
  logic sclk;
  logic mosi;
  logic deploy_select;
  logic sensor_select;
  logic miso_o;
  logic miso_oe;
  // Arming port pins.
  logic arm_sclk;
  logic arm_mosi;
  logic arm_select;
  logic arm_miso_o;
  logic arm_miso_oe;
  // Resolved data lines seen by the master; a released line reads low, as if weakly pulled down.
  wire miso;
  wire arm_miso;
  assign miso = miso_oe ? miso_o : 1'b0;
  assign arm_miso = arm_miso_oe ? arm_miso_o : 1'b0;
  // Device end.
  modport dev (
    input sclk, mosi, deploy_select, sensor_select, arm_sclk, arm_mosi, arm_select,
    output miso_o, miso_oe, arm_miso_o, arm_miso_oe
  );
  // Master end.
  modport host (
    output sclk, mosi, deploy_select, sensor_select, arm_sclk, arm_mosi, arm_select,
    input miso, arm_miso
  );
endinterface : sqa_link_if

/* hdl/sqa_host.sv */
// Serial master end that drives the deploy, sensor and arming ports.
`timescale 1ns/1ps
module sqa_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link pins.
  sqa_link_if.host link,
  // User request.
  input wire logic req,
  input wire logic [1:0] req_port,
  input wire logic [7:0] req_len,
  input wire logic [63:0] req_data,
  // User answer.
  output logic busy,
  output logic done,
  output logic [63:0] rx_data
);
  // Transfer phases.
  typedef enum logic [2:0] {SQA_IDLE, SQA_LEAD, SQA_LOW, SQA_HIGH, SQA_LAG, SQA_GAP} sqa_hst_t;
  sqa_hst_t state;
  // Phase timer, bits left, port and outgoing data.
  logic [7:0] tmr;
  logic [7:0] left;
  logic [1:0] port;
  logic [63:0] txd;
  // Two-stage synchronisers for the returning data lines.
  logic [1:0] miso_sy;
  logic [1:0] amiso_sy;
  // Flops behind the driven pins.
  logic sclk_q;
  logic asclk_q;
  logic mosi_q;
  logic dsel_q;
  logic ssel_q;
  logic asel_q;

  assign link.sclk = sclk_q;
  assign link.arm_sclk = asclk_q;
  assign link.mosi = mosi_q;
  assign link.arm_mosi = mosi_q;
  assign link.deploy_select = dsel_q;
  assign link.sensor_select = ssel_q;
  assign link.arm_select = asel_q;

  // Bring the data lines into this clock before they are sampled.
  always_ff @(posedge clk) begin
    miso_sy <= {miso_sy[0], link.miso};
    amiso_sy <= {amiso_sy[0], link.arm_miso};
  end

  // Transfer engine: clock made by dividing clk, data MSB first.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SQA_IDLE;
      tmr <= 8'h00;
      left <= 8'h00;
      port <= 2'h0;
      txd <= 64'h0;
      sclk_q <= 1'b0;
      asclk_q <= 1'b0;
      mosi_q <= 1'b0;
      dsel_q <= 1'b0;
      ssel_q <= 1'b0;
      asel_q <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rx_data <= 64'h0;
    end else begin
      done <= 1'b0;
      unique case (state)
        SQA_IDLE: begin
          // Clocks stay low while no select is asserted.
          sclk_q <= 1'b0;
          asclk_q <= 1'b0;
          if (req && req_len != 8'h00) begin
            port <= req_port;
            left <= req_len;
            txd <= {req_data[62:0], 1'b0};
            mosi_q <= req_data[63];
            dsel_q <= (req_port == sqa_pkg::PORT_DEP);
            ssel_q <= (req_port == sqa_pkg::PORT_SENS);
            asel_q <= (req_port == sqa_pkg::PORT_ARM);
            busy <= 1'b1;
            rx_data <= 64'h0;
            tmr <= 8'(sqa_pkg::LEAD_CYC);
            state <= SQA_LEAD;
          end
        end
        SQA_LEAD, SQA_LOW: begin
          // Low phase ends with a rising edge where the answer is taken.
          if (tmr == 8'h01) begin
            if (port == sqa_pkg::PORT_ARM) begin
              asclk_q <= 1'b1;
              rx_data <= {rx_data[62:0], amiso_sy[1]};
            end else begin
              sclk_q <= 1'b1;
              rx_data <= {rx_data[62:0], miso_sy[1]};
            end
            left <= left - 8'h01;
            tmr <= 8'(sqa_pkg::HALF_CYC);
            state <= SQA_HIGH;
          end else begin
            tmr <= tmr - 8'h01;
          end
        end
        SQA_HIGH: begin
          // High phase ends with a falling edge; next bit goes out then.
          if (tmr == 8'h01) begin
            sclk_q <= 1'b0;
            asclk_q <= 1'b0;
            if (left != 8'h00) begin
              mosi_q <= txd[63];
              txd <= {txd[62:0], 1'b0};
              tmr <= 8'(sqa_pkg::HALF_CYC);
              state <= SQA_LOW;
            end else begin
              tmr <= 8'(sqa_pkg::LAG_CYC);
              state <= SQA_LAG;
            end
          end else begin
            tmr <= tmr - 8'h01;
          end
        end
        SQA_LAG: begin
          // Negate the select once the lag time has run.
          if (tmr == 8'h01) begin
            dsel_q <= 1'b0;
            ssel_q <= 1'b0;
            asel_q <= 1'b0;
            tmr <= 8'(sqa_pkg::SEL_OFF_CYC);
            state <= SQA_GAP;
          end else begin
            tmr <= tmr - 8'h01;
          end
        end
        SQA_GAP: begin
          // Keep every select negated for the select off time.
          if (tmr == 8'h01) begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= SQA_IDLE;
          end else begin
            tmr <= tmr - 8'h01;
          end
        end
      endcase
    end
  end
endmodule : sqa_host

/* hdl/sqa_device.sv */
// Device end: serial slave ports, arming latch, stretch timers and firing.
//
// Overview of operation
// - Deploy frame needs 16 clocks, else fault answer.
// - Sensor frame needs 64 clocks, else fault queued.
// - Arming latched only on multiples of eight clocks.
// - Arming answer: status byte, then echoed command.
// - First eight bits falling edge, later rising.
// - Deploy and sensor selects together: command ignored.
// - Select assertion enables output, snapshots status.
// - Output released while its select is negated.
// - Master keeps selects negated select_off_time between.
// - Select pulses 50 ns or shorter change nothing.
// - Sample on rising clock, drive on falling.
// - Master holds serial clocks low while idle.
// - Most significant bit first, both directions.
// - Completed deployment sets channel success flag.
// - Drivers on only during a valid deployment.
// - Arm select negation starts requested stretch timers.
// - Fire needs enable pin and crossed partner command.
// - Deployment runs fire_duration, stopped only by reset.
// - Deploy enable starts or restarts its timer.
// - Deploy disable stops only deploy-started timers.
// - Arm enable starts or restarts its timer.
// - Arm disable stops only arm-started timers.
// - Enable pin low: no deploy timer, status kept.
`timescale 1ns/1ps
module sqa_device #(
  parameter int FIRE_CYC = sqa_pkg::FIRE_CYC_DEF,
  parameter int STRETCH_CYC = sqa_pkg::STRETCH_CYC_DEF
) (
  // System clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link pins.
  sqa_link_if.dev link,
  // Deployment enable pin, asynchronous.
  input wire logic deploy_enable_pin,
  // Sensor answer word and sensor queue push.
  input wire logic [63:0] sensor_status,
  output logic fifo_push,
  output logic [63:0] fifo_data,
  // Squib drivers and success flags.
  output logic [3:0] high_side_driver,
  output logic [3:0] low_side_driver,
  output logic [3:0] deploy_success
);
  localparam int N = sqa_pkg::NCH;
  localparam int CW = sqa_pkg::CNT_W;
  // Raw selects: deploy, sensor, arm.
  logic [2:0] sel_pin;
  // Free-running edge counters on each link clock.
  logic [CW-1:0] scnt;
  logic [CW-1:0] acnt;
  // Received bits on each link clock.
  logic [63:0] srx;
  logic [7:0] arx;
  // Counter snapshots at select assertion, per select.
  logic [CW-1:0] base [3];
  // Frame end accepted and its bit count, per select.
  logic [2:0] fend;
  logic [CW-1:0] nbits [3];
  // Rise of each synchronised select.
  logic [2:0] srise;
  // Both deploy and sensor selects seen together in this frame.
  logic clash;
  // Synchronised enable pin.
  logic [1:0] deploy_enable_pin_sy;
  // Status snapshots shifted out by each port.
  logic [15:0] dep_word;
  logic [63:0] sens_word;
  logic [7:0] arm_word;
  // Last deploy command byte, fault answer pending.
  logic [7:0] dcmd;
  logic dep_fault;
  // Accepted commands this cycle.
  logic dep_ev;
  logic arm_ev;
  logic [7:0] acmd;
  // Per channel timers and firing.
  logic [N-1:0] arm_run;
  logic [N-1:0] dep_run;
  logic [N-1:0] firing;
  // Link-side output flops, and the frame counts, selected word and bit index that feed them.
  logic sbit;
  logic aearly;
  logic aecho;
  logic [CW-1:0] sdiff;
  logic [CW-1:0] adiff;
  logic [63:0] sword;
  logic [7:0] slen;
  logic [7:0] sidx;

  assign sel_pin = {link.arm_select, link.sensor_select, link.deploy_select};

  // Edge counter and input shift register on the shared clock.
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      scnt <= '0;
      srx <= 64'h0;
    end else begin
      scnt <= scnt + CW'(1);
      srx <= {srx[62:0], link.mosi};
    end
  end

  // Edge counter, input shift register and echo flop on the arming clock.
  always_ff @(posedge link.arm_sclk or posedge rst) begin
    if (rst) begin
      acnt <= '0;
      arx <= 8'h00;
      aecho <= 1'b0;
    end else begin
      acnt <= acnt + CW'(1);
      arx <= {arx[6:0], link.arm_mosi};
      // From the eighth edge on, pass the oldest received bit on.
      if (adiff >= CW'(7)) aecho <= arx[6];
    end
  end

  // Bits taken so far in the current frame; counters are idle across a select edge.
  assign sdiff = scnt - base[0 + int'(link.sensor_select)];
  assign adiff = acnt - base[2];
  // Word and length of the port that is selected.
  assign sword = link.deploy_select ? {48'h0, dep_word} : sens_word;
  assign slen = link.deploy_select ? 8'(sqa_pkg::DEP_BITS) : 8'(sqa_pkg::SENS_BITS);
  assign sidx = slen - 8'h01 - 8'(sdiff);

  // Next bit goes out on the falling edge, MSB first.
  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) sbit <= 1'b0;
    else sbit <= sword[sidx[5:0]];
  end

  // Status byte bits go out on falling edges for the first eight bits.
  always_ff @(negedge link.arm_sclk or posedge rst) begin
    if (rst) aearly <= 1'b0;
    else if (adiff < CW'(8)) aearly <= arm_word[3'(7 - int'(adiff))];
  end

  // Outputs are driven only while their select is asserted.
  assign link.miso_oe = link.deploy_select | link.sensor_select;
  assign link.miso_o = (sdiff == '0) ? sword[sidx[5:0]] : sbit;
  assign link.arm_miso_oe = link.arm_select;
  assign link.arm_miso_o = (adiff == '0) ? arm_word[7] : ((adiff >= CW'(8)) ? aecho : aearly);

  // Per select: synchroniser, width filter, count snapshots, frame end.
  for (genvar i = 0; i < 3; i++) begin : g_sel
    logic [1:0] sy;
    logic prev;
    logic [7:0] wid;
    logic [CW-1:0] now_cnt;
    assign now_cnt = (i == 2) ? acnt : scnt;
    assign srise[i] = sy[1] & ~prev;
    always_ff @(posedge clk) begin
      if (rst) begin
        sy <= 2'b00;
        prev <= 1'b0;
        wid <= 8'h00;
        base[i] <= '0;
        nbits[i] <= '0;
        fend[i] <= 1'b0;
      end else begin
        sy <= {sy[0], sel_pin[i]};
        prev <= sy[1];
        // Width counter saturates; a short pulse never yields a frame end.
        if (!sy[1]) wid <= 8'h00;
        else if (wid != 8'hFF) wid <= wid + 8'h01;
        if (srise[i]) base[i] <= now_cnt;
        fend[i] <= prev & ~sy[1] & (wid > 8'(sqa_pkg::SPUR_CYC));
        nbits[i] <= now_cnt - base[i];
      end
    end
  end

  // Track a deploy and sensor select overlap through the frame.
  always_ff @(posedge clk) begin
    if (rst) clash <= 1'b0;
    else if (g_sel[0].sy[1] & g_sel[1].sy[1]) clash <= 1'b1;
    else if (srise[0] | srise[1]) clash <= 1'b0;
  end

  // Synchronise the enable pin.
  always_ff @(posedge clk) begin
    if (rst) deploy_enable_pin_sy <= 2'b00;
    else deploy_enable_pin_sy <= {deploy_enable_pin_sy[0], deploy_enable_pin};
  end

  // Deploy frame check: command kept for status whatever the enable pin.
  always_ff @(posedge clk) begin
    if (rst) begin
      dep_ev <= 1'b0;
      dcmd <= 8'h00;
      dep_fault <= 1'b0;
    end else begin
      dep_ev <= 1'b0;
      if (fend[0]) begin
        if (nbits[0] == CW'(sqa_pkg::DEP_BITS) && !clash) begin
          dep_ev <= 1'b1;
          dcmd <= srx[7:0];
          dep_fault <= 1'b0;
        end else begin
          dep_fault <= 1'b1;
        end
      end
    end
  end

  // Sensor frame check: bad count pushes the fault code instead.
  always_ff @(posedge clk) begin
    if (rst) begin
      fifo_push <= 1'b0;
      fifo_data <= 64'h0;
    end else begin
      fifo_push <= fend[1];
      if (fend[1]) begin
        if (nbits[1] == CW'(sqa_pkg::SENS_BITS) && !clash) fifo_data <= srx;
        else fifo_data <= sqa_pkg::SENS_BITCNT_FAULT;
      end
    end
  end

  // Arming frame: latch only on a whole number of bytes.
  always_ff @(posedge clk) begin
    if (rst) begin
      arm_ev <= 1'b0;
      acmd <= 8'h00;
    end else begin
      arm_ev <= fend[2] && nbits[2][2:0] == 3'h0 && nbits[2] != '0;
      if (fend[2]) acmd <= arx;
    end
  end

  // Status snapshots taken as each select is asserted.
  always_ff @(posedge clk) begin
    if (rst) begin
      dep_word <= 16'h0000;
      sens_word <= 64'h0;
      arm_word <= 8'h00;
    end else begin
      if (srise[0]) dep_word <= dep_fault ? sqa_pkg::DEP_FAULT_RSP
                                          : {deploy_success, firing, dcmd};
      if (srise[1]) sens_word <= sensor_status;
      if (srise[2]) arm_word <= {arm_run, dep_run};
    end
  end

  // Per channel stretch timers, firing and success flag.
  for (genvar c = 0; c < N; c++) begin : g_ch
    logic [sqa_pkg::TMR_W-1:0] at;
    logic [sqa_pkg::TMR_W-1:0] dt;
    logic [sqa_pkg::TMR_W-1:0] ft;
    logic a_en;
    logic a_dis;
    logic d_en;
    logic d_dis;
    logic fire_go;
    logic fire_end;
    assign a_en = arm_ev & acmd[sqa_pkg::EN_LSB + c];
    assign a_dis = arm_ev & acmd[sqa_pkg::DIS_LSB + c];
    assign d_en = dep_ev & dcmd[sqa_pkg::EN_LSB + c];
    assign d_dis = dep_ev & dcmd[sqa_pkg::DIS_LSB + c];
    // Fire only with the pin high and a crossed partner command.
    assign fire_go = deploy_enable_pin_sy[1] & ((d_en & arm_run[c]) | (a_en & dep_run[c]));
    assign fire_end = firing[c] && ft == sqa_pkg::TMR_W'(1);
    always_ff @(posedge clk) begin
      if (rst) begin
        arm_run[c] <= 1'b0;
        dep_run[c] <= 1'b0;
        firing[c] <= 1'b0;
        at <= '0;
        dt <= '0;
        ft <= '0;
        high_side_driver[c] <= 1'b0;
        low_side_driver[c] <= 1'b0;
      end else if (firing[c]) begin
        // A running deployment ignores every command until done.
        ft <= ft - sqa_pkg::TMR_W'(1);
        if (fire_end) begin
          firing[c] <= 1'b0;
          high_side_driver[c] <= 1'b0;
          low_side_driver[c] <= 1'b0;
        end
      end else if (fire_go) begin
        firing[c] <= 1'b1;
        ft <= sqa_pkg::TMR_W'(FIRE_CYC);
        high_side_driver[c] <= 1'b1;
        low_side_driver[c] <= 1'b1;
        arm_run[c] <= 1'b0;
        dep_run[c] <= 1'b0;
      end else begin
        // Arm-started timer: only arming commands touch it.
        if (a_en) begin
          arm_run[c] <= 1'b1;
          at <= sqa_pkg::TMR_W'(STRETCH_CYC);
        end else if (a_dis) begin
          arm_run[c] <= 1'b0;
        end else if (arm_run[c]) begin
          at <= at - sqa_pkg::TMR_W'(1);
          if (at == sqa_pkg::TMR_W'(1)) arm_run[c] <= 1'b0;
        end
        // Deploy-started timer: needs the pin, only deploy commands touch it.
        if (d_en && deploy_enable_pin_sy[1]) begin
          dep_run[c] <= 1'b1;
          dt <= sqa_pkg::TMR_W'(STRETCH_CYC);
        end else if (d_dis) begin
          dep_run[c] <= 1'b0;
        end else if (dep_run[c]) begin
          dt <= dt - sqa_pkg::TMR_W'(1);
          if (dt == sqa_pkg::TMR_W'(1)) dep_run[c] <= 1'b0;
        end
      end
    end
    // Success flag: completion sets it, an accepted deploy frame clears it.
    always_ff @(posedge clk) begin
      if (rst) deploy_success[c] <= 1'b0;
      else if (fire_end) deploy_success[c] <= 1'b1;
      else if (dep_ev) deploy_success[c] <= 1'b0;
    end
  end
endmodule : sqa_device

/* verification/sqa_link_props.sv */
// Wire-level assertions for the squib arming serial link.
`timescale 1ns/1ps
module sqa_link_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Deploy and sensor port pins.
  input wire logic sclk,
  input wire logic mosi,
  input wire logic deploy_select,
  input wire logic sensor_select,
  input wire logic miso_o,
  input wire logic miso_oe,
  // Arming port pins.
  input wire logic arm_sclk,
  input wire logic arm_mosi,
  input wire logic arm_select,
  input wire logic arm_miso_o,
  input wire logic arm_miso_oe
);
  // Either shared-port select is high.
  logic sel;
  // Idle cycles since the shared selects dropped, saturating.
  int off_cnt;
  // Rising arming clock edges seen in the current frame.
  int arm_cnt;
  assign sel = deploy_select | sensor_select;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Counts idle time so a new frame can be checked against the off time.
  always_ff @(posedge clk) begin
    if (rst) begin
      off_cnt <= sqa_pkg::SEL_OFF_CYC;
    end else if (sel) begin
      off_cnt <= 0;
    end else if (off_cnt < sqa_pkg::SEL_OFF_CYC) begin
      off_cnt <= off_cnt + 1;
    end
  end
  // Counts arming clock rises so head and tail bits can be told apart.
  always_ff @(posedge clk) begin
    if (rst || !arm_select) begin
      arm_cnt <= 0;
    end else if ($rose(arm_sclk)) begin
      arm_cnt <= arm_cnt + 1;
    end
  end
  a_miso_oe_follows: assert property (miso_oe == sel)
    else $error("shared data output enable differs from selects");
  a_arm_oe_follows: assert property (arm_miso_oe == arm_select)
    else $error("arming data output enable differs from select");
  a_sclk_idle_low: assert property (!sel |-> !sclk)
    else $error("shared clock high while idle");
  a_arm_sclk_idle: assert property (!arm_select |-> !arm_sclk)
    else $error("arming clock high while idle");
  a_select_off_gap: assert property ($rose(sel) |-> off_cnt >= sqa_pkg::SEL_OFF_CYC)
    else $error("select reasserted too soon");
  a_no_select_clash: assert property (!(deploy_select && sensor_select))
    else $error("deploy and sensor selects both high");
  a_mosi_rise_stable: assert property ((sel && $rose(sclk)) |-> $stable(mosi))
    else $error("master data moved at the sampling edge");
  a_miso_high_stable: assert property ((sel && sclk && $past(sclk)) |-> $stable(miso_o))
    else $error("shared output moved while clock high");
  a_arm_head_fall: assert property ((arm_select && arm_cnt < 8 && arm_sclk && $past(arm_sclk))
    |-> $stable(arm_miso_o))
    else $error("arming status bit moved while clock high");
  a_arm_tail_rise: assert property ((arm_select && arm_cnt >= 9 && !arm_sclk && !$past(arm_sclk))
    |-> $stable(arm_miso_o))
    else $error("arming echo bit moved while clock low");
  // Main traffic kinds seen on the wire.
  c_deploy_frame: cover property ($rose(deploy_select));
  c_sensor_frame: cover property ($rose(sensor_select));
  c_arm_two_bytes: cover property (arm_select && arm_cnt == 16);
endmodule : sqa_link_props

/* verification/squib_spi_arming_control_tb.sv */
// Self-checking bench joining the master and device ends of the link.
`timescale 1ns/1ps
module squib_spi_arming_control_tb;
  // Shortened fire and stretch lengths in clock cycles.
  localparam int FIRE = 50;
  localparam int STR = 3000;
  // Clock, reset, user side and device pins.
  logic clk, rst, req, busy, done, pin, fifo_push;
  logic [1:0] req_port;
  logic [7:0] req_len, c;
  logic [63:0] req_data, rx_data, sensor_status, fifo_data, rx, w;
  logic [3:0] hsd, lsd, succ;
  int n_mismatch, num_checks, cycles, seed, n_push;
  int fire_cnt [4];
  sqa_link_if link ();
  sqa_host sqa_host_inst (.clk(clk), .rst(rst), .link(link), .req(req), .req_port(req_port),
    .req_len(req_len), .req_data(req_data), .busy(busy), .done(done), .rx_data(rx_data));
  sqa_device #(.FIRE_CYC(FIRE), .STRETCH_CYC(STR)) sqa_device_inst (.clk(clk), .rst(rst),
    .link(link), .deploy_enable_pin(pin), .sensor_status(sensor_status),
    .fifo_push(fifo_push), .fifo_data(fifo_data), .high_side_driver(hsd),
    .low_side_driver(lsd), .deploy_success(succ));
  sqa_link_props sqa_link_props_inst (.clk(clk), .rst(rst), .sclk(link.sclk),
    .mosi(link.mosi), .deploy_select(link.deploy_select), .sensor_select(link.sensor_select),
    .miso_o(link.miso_o), .miso_oe(link.miso_oe), .arm_sclk(link.arm_sclk),
    .arm_mosi(link.arm_mosi), .arm_select(link.arm_select), .arm_miso_o(link.arm_miso_o),
    .arm_miso_oe(link.arm_miso_oe));
  // System clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Prints the verdict and stops the run.
  task end_sim;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // Compares one value and reports a mismatch at once.
  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Arming status byte: arming timers above, deploy timers below.
  function automatic logic [7:0] stat(input logic [3:0] a, input logic [3:0] d);
    return {a, d};
  endfunction : stat
  // Runs one master transfer and keeps the received bits.
  task xfer(input logic [1:0] p, input logic [7:0] n, input logic [63:0] d);
    int k;
    @(posedge clk);
    #1;
    req_port = p;
    req_len = n;
    req_data = d;
    req = 1'b1;
    @(posedge clk);
    #1;
    req = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("transfer done", 64'h1, {63'h0, done});
    chk("busy after done", 64'h0, {63'h0, busy});
    rx = rx_data;
  endtask : xfer
  // One deploy frame carrying command byte b.
  task dep(input logic [7:0] b);
    xfer(sqa_pkg::PORT_DEP, 8'h10, {8'h00, b, 48'h0});
  endtask : dep
  // One single-byte arming frame.
  task arm(input logic [7:0] b);
    xfer(sqa_pkg::PORT_ARM, 8'h08, {b, 56'h0});
  endtask : arm
  // Waits a number of cycles, ending just after an edge.
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // Counts firing cycles per channel; both drivers must move together.
  always @(posedge clk) begin
    if (!rst) begin
      if (fifo_push === 1'b1) n_push++;
      for (int i = 0; i < 4; i++) begin
        if (hsd[i] === 1'b1) fire_cnt[i]++;
        if (hsd[i] !== lsd[i]) chk("driver pair", {63'h0, hsd[i]}, {63'h0, lsd[i]});
      end
    end
  end
  // Main sequence.
  initial begin
    seed = 32'hA1131886;
    // Start low so the link-clock flops see a clean rising reset edge.
    rst = 1'b0;
    n_push = 0;
    #1;
    rst = 1'b1;
    req = 1'b0;
    req_port = 2'h0;
    req_len = 8'h00;
    req_data = 64'h0;
    pin = 1'b0;
    sensor_status = 64'h0;
    n_mismatch = 0;
    num_checks = 0;
    cycles = 0;
    foreach (fire_cnt[i]) fire_cnt[i] = 0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    // A short deploy frame is refused and the next answer is the fault word.
    xfer(sqa_pkg::PORT_DEP, 8'h0F, 64'h0);
    dep(8'h00);
    chk("deploy fault", {48'h0, sqa_pkg::DEP_FAULT_RSP}, {48'h0, rx[15:0]});
    // With the pin low a deploy enable is echoed but starts no timer.
    dep(8'h80);
    dep(8'h00);
    chk("deploy echo", 64'h80, {56'h0, rx[7:0]});
    arm(8'h00);
    chk("status pin low", {56'h0, stat(4'h0, 4'h0)}, {56'h0, rx[7:0]});
    // A seven-clock arming frame is dropped.
    pin = 1'b1;
    idle(4);
    xfer(sqa_pkg::PORT_ARM, 8'h07, {8'hF0, 56'h0});
    arm(8'h00);
    chk("odd arm frame", {56'h0, stat(4'h0, 4'h0)}, {56'h0, rx[7:0]});
    // Two-byte arming frame: status byte then the first byte echoed.
    dep(8'h10);
    xfer(sqa_pkg::PORT_ARM, 8'h10, {8'h0A, 8'h05, 48'h0});
    chk("arm answer", {48'h0, stat(4'h0, 4'h1), 8'h0A}, {48'h0, rx[15:0]});
    // Deploy disable stops the deploy timer, so a later arm cannot fire.
    dep(8'h01);
    arm(8'h10);
    chk("dep stopped", {56'h0, stat(4'h0, 4'h0)}, {56'h0, rx[7:0]});
    idle(100);
    chk("no fire ch0", 64'h0, 64'(fire_cnt[0]));
    // Deploy disable leaves an arm timer alone; deploy enable then fires.
    arm(8'h40);
    chk("arm running", {56'h0, stat(4'h1, 4'h0)}, {56'h0, rx[7:0]});
    dep(8'h04);
    dep(8'h40);
    idle(200);
    chk("fire length ch2", 64'(FIRE), 64'(fire_cnt[2]));
    chk("success flag", 64'h4, {60'h0, succ});
    // Arm command during a deploy-started timer fires too.
    idle(STR + 100);
    dep(8'hA0);
    arm(8'h80);
    chk("dep running", {56'h0, stat(4'h0, 4'hA)}, {56'h0, rx[7:0]});
    idle(200);
    chk("fire length ch3", 64'(FIRE), 64'(fire_cnt[3]));
    // An expired deploy timer no longer lets an arm command fire.
    idle(STR + 100);
    arm(8'h20);
    idle(200);
    chk("expired ch1", 64'h0, 64'(fire_cnt[1]));
    // Random sensor words travel whole, most significant bit first.
    for (int i = 0; i < 3; i++) begin
      w = {$random(seed), $random(seed)};
      sensor_status = {$random(seed), $random(seed)};
      xfer(sqa_pkg::PORT_SENS, 8'h40, w);
      chk("sensor answer", sensor_status, rx);
      chk("sensor word", w, fifo_data);
    end
    xfer(sqa_pkg::PORT_SENS, 8'h3F, w);
    chk("sensor fault", sqa_pkg::SENS_BITCNT_FAULT, fifo_data);
    chk("sensor pushes", 64'h4, 64'(n_push));
    // Random deploy commands with the pin low are echoed and never fire.
    pin = 1'b0;
    idle(4);
    c = 8'hA0;
    for (int i = 0; i < 3; i++) begin
      w = {$random(seed), $random(seed)};
      dep(w[7:0]);
      chk("random echo", {56'h0, c}, {56'h0, rx[7:0]});
      c = w[7:0];
    end
    idle(100);
    chk("pin low no fire", 64'(2 * FIRE), 64'(fire_cnt.sum()));
    end_sim();
  end
endmodule : squib_spi_arming_control_tb
